// [design/smbsp_port.v]
// Overview of operation
// - answer to fixed 7-bit address 0x2E, and to the alert response address while alerting
// - first byte after start is address plus direction, 0x5C for write
// - nine clocks per byte: eight data bits MSB first, then ack
// - sda changes only with scl low; rise while high is stop
// - direction fixed at start; changing it needs a new start
// - writes carry one or two bytes; reads supply one byte
// - first written byte always loads the register pointer
// - second written byte goes to the pointed register
// - a read without pointer write uses the retained pointer
// - send byte: address, ack, pointer byte, ack, stop
// - repeated start may replace stop; read then uses new pointer
// - write byte: slave acks address, pointer and data
// - read byte: pointer write then read of selected register
// - active-low alert output when a value leaves its limits
// - receive byte: ack address, send one byte, master nacks
// - 35 ms without bus activity mid-transfer releases sda, except during the ack of the written data byte
// - bit 6 of configuration register 1 disables the timeout
// - while alerting, answer alert response address with own address
`timescale 1ns/100ps
`include "smbsp_consts.vh"

module smbsp_port
#(
  parameter TIMEOUT_CYCLES = `SMBSP_TIMEOUT_CYC,
  parameter [6:0] DEV_ADDR = `SMBSP_OWN_ADDR
)
(
  input  wire       clk_sys,
  input  wire       sys_rst,
  input  wire       sclIn,
  input  wire       sdaIn,
  output reg        sdaOut,
  output reg        sdaOe_n,
  input  wire       alertPinMode,
  input  wire       outOfLimit,
  output reg        alert_n,
  output reg  [7:0] regPtr,
  output reg  [7:0] regWrData,
  output reg        regWrStrobe,
  input  wire [7:0] regRdData,
  output reg  [7:0] cfg1
);

  // ----------------------------------------------------------------
  // states
  // ----------------------------------------------------------------
  localparam [5:0] ST_IDLE = 6'h01;
  localparam [5:0] ST_ADDR = 6'h02;
  localparam [5:0] ST_WPTR = 6'h04;
  localparam [5:0] ST_WDAT = 6'h08;
  localparam [5:0] ST_READ = 6'h10;
  localparam [5:0] ST_IGN  = 6'h20;

  // ----------------------------------------------------------------
  // pin sampling and edge finding
  // ----------------------------------------------------------------
  wire [1:0] pins;
  reg        sclQ;
  reg        sdaQ;

  smbsp_sync #(.WIDTH(2)) uSync
  (
    .clk_sys (clk_sys),
    .sys_rst (sys_rst),
    .asyncIn ({sclIn, sdaIn}),
    .syncOut (pins)
  );

  wire scl = pins[1];
  wire sda = pins[0];

  always @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      sclQ <= 1'b1;
      sdaQ <= 1'b1;
    end
    else
    begin
      sclQ <= scl;
      sdaQ <= sda;
    end
  end

  wire sclRise = scl & ~sclQ;
  wire sclFall = ~scl & sclQ;
  wire startCond = scl & sclQ & sdaQ & ~sda;
  wire stopCond  = scl & sclQ & ~sdaQ & sda;

  // ----------------------------------------------------------------
  // byte engine
  // ----------------------------------------------------------------
  reg [5:0] state;
  reg [3:0] bitCnt;
  reg [7:0] shiftIn;
  reg [7:0] shiftOut;
  reg       isAra;
  reg       inAck;
  reg       drive;
  reg       mAck;
  wire      tmoExpired;

  wire       busy = (state != ST_IDLE) && (state != ST_IGN);
  wire [7:0] rxByte = {shiftIn[6:0], sda};
  // judged at the eighth fall, when shiftIn already holds the whole byte
  wire       ownHit = (shiftIn[7:1] == DEV_ADDR);
  wire       araHit = (shiftIn[7:1] == `SMBSP_ARA_ADDR) & shiftIn[0]
                      & ~alert_n;

  smbsp_timeout #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) uTmo
  (
    .clk_sys  (clk_sys),
    .sys_rst  (sys_rst),
    .busy     (busy),
    .activity (sclRise | sclFall),
    .toDisable (cfg1[`SMBSP_BUS_TIMEOUT_DISABLE_BIT]),
    .expired  (tmoExpired)
  );

  always @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      state       <= ST_IDLE;
      bitCnt      <= 4'h0;
      shiftIn     <= 8'h00;
      shiftOut    <= 8'h00;
      isAra       <= 1'b0;
      inAck       <= 1'b0;
      drive       <= 1'b0;
      mAck        <= 1'b0;
      regPtr      <= 8'h00;
      regWrData   <= 8'h00;
      regWrStrobe <= 1'b0;
      cfg1        <= `SMBSP_CFG1_RESET;
    end
    else
    begin
      regWrStrobe <= 1'b0;
      if (startCond)
      begin
        // repeated start reopens the address phase; pointer kept
        state  <= ST_ADDR;
        bitCnt <= 4'h0;
        inAck  <= 1'b0;
        drive  <= 1'b0;
      end
      else if (stopCond || tmoExpired)
      begin
        state <= ST_IDLE;
        drive <= 1'b0;
        inAck <= 1'b0;
      end
      else
      begin
        case (state)
          ST_IDLE, ST_IGN:
          begin
            // a pending data ack must last through its ninth clock
            if (sclFall)
              drive <= 1'b0;
          end
          default:
          begin
            if (sclRise && !inAck)
            begin
              shiftIn <= rxByte;
              bitCnt  <= bitCnt + 4'h1;
            end
            if (sclRise && inAck && state == ST_READ)
              mAck <= ~sda;
            if (sclFall && !inAck && bitCnt == 4'h8)
            begin
              inAck  <= 1'b1;
              bitCnt <= 4'h0;
              case (state)
                ST_ADDR:
                begin
                  if (ownHit || araHit)
                  begin
                    drive <= 1'b1;
                    isAra <= araHit;
                    state <= shiftIn[0] ? ST_READ : ST_WPTR;
                  end
                  else
                    state <= ST_IGN;
                end
                ST_WPTR:
                begin
                  regPtr <= shiftIn;
                  drive  <= 1'b1;
                  state  <= ST_WDAT;
                end
                ST_WDAT:
                begin
                  regWrData   <= shiftIn;
                  regWrStrobe <= 1'b1;
                  if (regPtr == `SMBSP_CFG1_INDEX)
                    cfg1 <= shiftIn;
                  drive <= 1'b1;
                  state <= ST_IGN;
                end
                default:
                begin
                  // read: master acks, slave releases
                  drive <= 1'b0;
                  if (!mAck)
                    state <= ST_IGN;
                end
              endcase
              if (state == ST_READ)
                inAck <= 1'b1;
            end
            else if (sclFall && inAck)
            begin
              inAck <= 1'b0;
              if (state == ST_READ)
              begin
                // one data byte per read; address phase loads it
                shiftOut <= isAra ? {DEV_ADDR, 1'b1}
                                  : (regPtr == `SMBSP_CFG1_INDEX
                                     ? cfg1 : regRdData);
                drive    <= 1'b0;
              end
              else
                drive <= 1'b0;
            end
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // sda driver; data bits change only after scl falls
  // ----------------------------------------------------------------
  reg       rdPhase;
  reg [3:0] rdBit;

  always @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      rdPhase <= 1'b0;
      rdBit   <= 4'h0;
      sdaOut  <= 1'b1;
      sdaOe_n <= 1'b1;
    end
    else
    begin
      if (state != ST_READ || startCond || stopCond || tmoExpired)
      begin
        rdPhase <= 1'b0;
        rdBit   <= 4'h0;
      end
      else if (sclFall && inAck && !rdPhase)
      begin
        rdPhase <= 1'b1;
        rdBit   <= 4'h0;
      end
      else if (rdPhase && sclFall)
      begin
        if (rdBit == 4'h8)
          rdPhase <= 1'b0;
        rdBit <= rdBit + 4'h1;
      end
      if (drive)
      begin
        sdaOut  <= 1'b0;
        sdaOe_n <= 1'b0;
      end
      else if (rdPhase && rdBit < 4'h8)
      begin
        sdaOut  <= 1'b0;
        sdaOe_n <= shiftOut[3'h7 - rdBit[2:0]];
      end
      else
      begin
        sdaOut  <= 1'b1;
        sdaOe_n <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // alert output; held only while the pin is in alert mode
  // ----------------------------------------------------------------
  always @(posedge clk_sys)
  begin
    if (sys_rst)
      alert_n <= 1'b1;
    else
      alert_n <= ~(alertPinMode & outOfLimit);
  end

endmodule

// [design/smbsp_consts.vh]
`ifndef SMBSP_CONSTS_VH
`define SMBSP_CONSTS_VH

// ----------------------------------------------------------------
// bus addressing
// ----------------------------------------------------------------
`define SMBSP_OWN_ADDR       7'h2E
`define SMBSP_WRITE_BYTE     8'h5C
`define SMBSP_ARA_ADDR       7'h0C

// ----------------------------------------------------------------
// configuration register 1 fields
// ----------------------------------------------------------------
`define SMBSP_CFG1_INDEX     8'h40
`define SMBSP_CFG1_RESET     8'h00
`define SMBSP_BUS_TIMEOUT_DISABLE_BIT 6

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define SMBSP_CLK_HZ         20000000
`define SMBSP_TIMEOUT_MS     35
`define SMBSP_TIMEOUT_CYC    ((`SMBSP_CLK_HZ / 1000) * `SMBSP_TIMEOUT_MS)

`endif

// [design/smbsp_sync.v]
`timescale 1ns/100ps
`include "smbsp_consts.vh"

// ----------------------------------------------------------------
// two-stage synchroniser, one per bit
// ----------------------------------------------------------------
module smbsp_sync
#(
  parameter WIDTH = 2
)
(
  input  wire             clk_sys,
  input  wire             sys_rst,
  input  wire [WIDTH-1:0] asyncIn,
  output wire [WIDTH-1:0] syncOut
);

  reg [WIDTH-1:0] stageA;
  reg [WIDTH-1:0] stageB;

  // resets to the idle-high bus level so no false start appears
  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1)
    begin : gBit
      always @(posedge clk_sys)
      begin
        if (sys_rst)
        begin
          stageA[i] <= 1'b1;
          stageB[i] <= 1'b1;
        end
        else
        begin
          stageA[i] <= asyncIn[i];
          stageB[i] <= stageA[i];
        end
      end
    end
  endgenerate

  assign syncOut = stageB;

endmodule

// [design/smbsp_timeout.v]
`timescale 1ns/100ps
`include "smbsp_consts.vh"

// ----------------------------------------------------------------
// bus inactivity timer
// ----------------------------------------------------------------
module smbsp_timeout
#(
  parameter TIMEOUT_CYCLES = `SMBSP_TIMEOUT_CYC
)
(
  input  wire clk_sys,
  input  wire sys_rst,
  input  wire busy,
  input  wire activity,
  input  wire toDisable,
  output reg  expired
);

  reg [31:0] count;

  always @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      count   <= 32'h0000_0000;
      expired <= 1'b0;
    end
    else
    begin
      expired <= 1'b0;
      if (!busy || activity || toDisable)
        count <= 32'h0000_0000;
      else if (count >= TIMEOUT_CYCLES - 1)
      begin
        count   <= 32'h0000_0000;
        expired <= 1'b1;
      end
      else
        count <= count + 32'h0000_0001;
    end
  end

endmodule

// [sim/smbsp_host.sv]
`timescale 1ns/100ps
// ----------------------------------------------
// bus host model, open drain with pull-up
// ----------------------------------------------
module smbsp_host
(
  output logic scl,
  output logic sda,
  input  logic sdaBus
);
  initial
  begin
    scl = 1'b1;
    sda = 1'b1;
  end
  // scl only toggles inside frames, rests high when idle
  task automatic bitX(input logic b, output logic r);
    #100 sda = b;
    #100 scl = 1'b1;
    #200 r = sdaBus;
    scl = 1'b0;
  endtask
  // ninth bit: 1 releases for an ack, or is the nack of a read
  task automatic xfer(input logic [7:0] dv, input logic m,
                      output logic [7:0] q, output logic a);
    for (int i = 7; i >= 0; i--)
      bitX(dv[i], q[i]);
    bitX(m, a);
    a = !a;
  endtask
  task automatic startC();
    #100 sda = 1'b1;
    #100 scl = 1'b1;
    #100 sda = 1'b0;
    #100 scl = 1'b0;
  endtask
  task automatic stopC();
    #100 sda = 1'b0;
    #100 scl = 1'b1;
    #100 sda = 1'b1;
    #200;
  endtask
endmodule

// [sim/smbsp_port_props.sv]
`timescale 1ns/100ps
// ----------------------------------------------
// checker on the port pins
// ----------------------------------------------
module smbsp_port_props
#(
  parameter TIMEOUT_CYCLES = 700000
)
(
  input logic       clk_sys,
  input logic       sys_rst,
  input logic       sclIn,
  input logic       sdaIn,
  input logic       sdaOut,
  input logic       sdaOe_n,
  input logic       alertPinMode,
  input logic       outOfLimit,
  input logic       alert_n,
  input logic [7:0] regPtr,
  input logic [7:0] regWrData,
  input logic       regWrStrobe,
  input logic [7:0] regRdData,
  input logic [7:0] cfg1
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  // counts cycles of sda held low while scl is frozen
  logic [19:0] stallCnt;
  always @(posedge clk_sys)
    if (sys_rst || sdaOe_n || $changed(sclIn))
      stallCnt <= 20'h00000;
    else
      stallCnt <= stallCnt + 20'h00001;
  property p_alert;
    !$past(sys_rst) |->
      alert_n == !($past(alertPinMode) && $past(outOfLimit));
  endproperty
  property p_strobe1; regWrStrobe |=> !regWrStrobe; endproperty
  property p_ptrAck; $changed(regPtr) |-> ##[0:20] !sdaOe_n; endproperty
  property p_strobeAck; regWrStrobe |-> ##[0:20] !sdaOe_n; endproperty
  property p_cfgPtr; $changed(cfg1) |-> regPtr == 8'h40; endproperty
  property p_cfgWr;
    regWrStrobe && regPtr == 8'h40 |-> ##[0:2] cfg1 == regWrData;
  endproperty
  property p_stopRel; sclIn && $rose(sdaIn) |-> ##[1:8] sdaOe_n; endproperty
  property p_timeout; !cfg1[6] |-> stallCnt < TIMEOUT_CYCLES + 16; endproperty
  a_alert: assert property (p_alert) else $error("alert wrong");
  a_strobe1: assert property (p_strobe1) else $error("long strobe");
  a_ptrAck: assert property (p_ptrAck) else $error("ptr no ack");
  a_strobeAck: assert property (p_strobeAck) else $error("no ack");
  a_cfgPtr: assert property (p_cfgPtr) else $error("cfg1 hit");
  a_cfgWr: assert property (p_cfgWr) else $error("cfg1 lost");
  a_stopRel: assert property (p_stopRel) else $error("held sda");
  a_timeout: assert property (p_timeout) else $error("no timeout");
  c_write: cover property (regWrStrobe);
  c_alert: cover property (!alert_n);
  c_bus_timeout_disable: cover property (cfg1[6]);
endmodule
bind smbsp_port smbsp_port_props #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) props_u
(
  .clk_sys(clk_sys), .sys_rst(sys_rst), .sclIn(sclIn), .sdaIn(sdaIn),
  .sdaOut(sdaOut), .sdaOe_n(sdaOe_n), .alertPinMode(alertPinMode),
  .outOfLimit(outOfLimit), .alert_n(alert_n), .regPtr(regPtr),
  .regWrData(regWrData), .regWrStrobe(regWrStrobe),
  .regRdData(regRdData), .cfg1(cfg1)
);

// [sim/smbsp_port_tb_top.sv]
`timescale 1ns/100ps
// ----------------------------------------------
// bench top
// ----------------------------------------------
module smbsp_port_tb_top;
  localparam TOC = 200;
  logic        clk_sys, sys_rst, alertPinMode, outOfLimit, a;
  logic [7:0]  regRdData, q, p, d;
  wire         scl, hostSda, sdaOut, sdaOe_n, alert_n, regWrStrobe;
  wire  [7:0]  regPtr, regWrData, cfg1;
  wire         sdaBus = hostSda & (sdaOe_n | sdaOut);
  logic [15:0] expQ[$];
  logic [7:0]  bad [3] = '{8'h5E, 8'h3C, 8'hDC};
  int          err_total, n_compared;
  initial
  begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  // register file stand-in, pointer-keyed so a wrong pointer shows
  always @(posedge clk_sys)
    regRdData <= regPtr ^ 8'hA5;
  smbsp_port #(.TIMEOUT_CYCLES(TOC)) dut_u
  (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .sclIn(scl), .sdaIn(sdaBus),
    .sdaOut(sdaOut), .sdaOe_n(sdaOe_n), .alertPinMode(alertPinMode),
    .outOfLimit(outOfLimit), .alert_n(alert_n), .regPtr(regPtr),
    .regWrData(regWrData), .regWrStrobe(regWrStrobe),
    .regRdData(regRdData), .cfg1(cfg1)
  );
  smbsp_host host_u (.scl(scl), .sda(hostSda), .sdaBus(sdaBus));
  task automatic chk(input logic [15:0] seen, input logic [15:0] ex);
    n_compared++;
    if (seen !== ex)
    begin
      err_total++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, ex);
    end
  endtask
  always @(posedge clk_sys)
    if (regWrStrobe === 1'b1)
      chk({regPtr, regWrData}, expQ.size() ? expQ.pop_front() : 16'hXXXX);
  task automatic print_verdict();
    $display("compared %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic wrOp(input logic [7:0] ad, input int n, input logic hit);
    if (hit && n > 1)
      expQ.push_back({p, d});
    host_u.startC();
    for (int i = 0; i <= n; i++)
    begin
      host_u.xfer(i == 0 ? ad : (i == 1 ? p : d), 1'b1, q, a);
      chk(a, hit && i < 3);
    end
  endtask
  task automatic rdOp(input logic [7:0] ad, e, input logic hit);
    host_u.startC();
    host_u.xfer(ad, 1'b1, q, a);
    chk(a, hit);
    host_u.xfer(8'hFF, 1'b1, q, a);
    chk(q, hit ? e : 8'hFF);
  endtask
  // stall scl low in the address ack slot
  task automatic stall(input logic rel);
    host_u.startC();
    for (int i = 7; i >= 0; i--)
      host_u.bitX(8'h5C >> i, a);
    repeat (10) @(posedge clk_sys);
    for (int i = 0; i < 4 * TOC && sdaOe_n !== 1'b1; i++)
      @(posedge clk_sys);
    chk(sdaOe_n, rel);
    if (!rel)
      host_u.bitX(1'b1, a);
    host_u.stopC();
  endtask
  initial
  begin
    {sys_rst, alertPinMode, outOfLimit, regRdData} = 11'h400;
    {err_total, n_compared, p, d} = 0;
    void'($urandom(32'h547F));
    repeat (16) @(posedge clk_sys);
    sys_rst <= 1'b0;
    repeat (4) @(posedge clk_sys);
    chk({regPtr, cfg1}, 16'h0000);
    chk({sdaOe_n, alert_n}, 16'h0003);
    $display("test reset done");
    foreach (bad[i])
    begin
      wrOp(bad[i], 2, 1'b0);
      host_u.stopC();
    end
    chk(regPtr, 16'h0000);
    $display("test foreign done");
    repeat (4)
    begin
      p = $urandom_range(8'h3F, 8'h00);
      d = $urandom;
      wrOp(8'h5C, 2, 1'b1);
      host_u.stopC();
      wrOp(8'h5C, 1, 1'b1);
      rdOp(8'h5D, p ^ 8'hA5, 1'b1);
      host_u.stopC();
      rdOp(8'h5D, p ^ 8'hA5, 1'b1);
      host_u.stopC();
      wrOp(8'h5C, 3, 1'b1);
      host_u.stopC();
    end
    $display("test access done");
    p = 8'h40;
    d = 8'h40;
    wrOp(8'h5C, 2, 1'b1);
    host_u.stopC();
    rdOp(8'h5D, 8'h40, 1'b1);
    host_u.stopC();
    stall(1'b0);
    d = 8'h00;
    wrOp(8'h5C, 2, 1'b1);
    host_u.stopC();
    stall(1'b1);
    $display("test timeout done");
    repeat (20)
    begin
      @(posedge clk_sys);
      alertPinMode <= 1'($urandom);
      outOfLimit <= 1'($urandom);
    end
    alertPinMode <= 1'b1;
    outOfLimit <= 1'b1;
    repeat (3) @(posedge clk_sys);
    chk(alert_n, 16'h0000);
    rdOp(8'h19, 8'h5D, 1'b1);
    host_u.stopC();
    outOfLimit <= 1'b0;
    repeat (3) @(posedge clk_sys);
    rdOp(8'h19, 8'h00, 1'b0);
    host_u.stopC();
    $display("test alert done");
    print_verdict();
  end
endmodule
